// ===== verilog/pfresp_pkg.sv
// pfresp_pkg: constants shared by the permanent-failure response block
// assumes nothing of its surroundings beyond a single 40 MHz clock
package pfresp_pkg;

  // -------------------------------------------------------------------
  // configuration byte field positions and reset value
  // -------------------------------------------------------------------
  localparam int unsigned CFG_W            = 8;
  localparam int unsigned BIT_SRC_SEL      = 7;
  localparam int unsigned BIT_RECORD_EN    = 5;
  localparam int unsigned BIT_BLOW_EN      = 4;
  localparam int unsigned BIT_SLEEP_EN     = 3;
  localparam int unsigned BIT_REG_OFF_EN   = 2;
  localparam int unsigned BIT_SWITCH_OFF   = 1;
  localparam logic [7:0]  CFG_RESET        = 8'h02;

  // -------------------------------------------------------------------
  // voltage and timing
  // -------------------------------------------------------------------
  localparam int unsigned VOLT_W           = 16;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned BLOW_TIME_NS     = 1000;
  localparam int unsigned BLOW_CYCLES      =
    (BLOW_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BLOW_CNT_W       = 8;

  // response sequencer states
  typedef enum logic [2:0]
  {
    PFR_IDLE,
    PFR_ACT,
    PFR_SLEEP_WAIT,
    PFR_SLEEP,
    PFR_DONE
  } pfresp_state_t;

endpackage

// ===== verilog/pfresp_blow_timer.sv
// pfresp_blow_timer: holds the fuse drive for a fixed number of cycles
// assumes start is a one-cycle pulse from the response sequencer
`timescale 1ns/1ps
module pfresp_blow_timer
  import pfresp_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      drive,
  output logic      done
);

  logic [BLOW_CNT_W-1:0] cnt_q;
  logic [BLOW_CNT_W-1:0] cnt_d;
  logic                  run_q;
  logic                  done_q;

  // -------------------------------------------------------------------
  // counter
  // -------------------------------------------------------------------
  // pulse width is fixed so the driver sees the same energy every time
  assign cnt_d = run_q ? cnt_q - 1'b1
                       : BLOW_CNT_W'(BLOW_CYCLES);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= (start || run_q) ? cnt_d : cnt_q;
      run_q  <= start ? 1'b1 : (run_q && cnt_q != 1) ;
      done_q <= done_q || (run_q && cnt_q == 1);
    end
  end

  assign drive = run_q;
  assign done  = done_q;

endmodule

// ===== verilog/pfresp_top.sv
// pfresp_top: permanent-failure response sequencer
// assumes detection, voltage readings and config bits are synchronous
// to clk; nvm programming handshake comes from on-chip logic
// Function
// - source select one: pack voltage gates blow
// - source select zero: stack voltage gates blow
// - record enable: program failure status into nvm
// - delay nvm programming until conditions allow
// - no write permit: keep status in ram
// - record disabled: status lost on reset
// - blow enable: blow fuse once voltage suffices
// - sleep enable: enter deepest sleep after failure
// - sleep waits for blow and programming
// - after failure hold switches off, ignore monitoring
// - regulator enable: turn regulators off
// - host command re-enables regulators
// - switch-off enable default one: switches off
`timescale 1ns/1ps
module pfresp_top
  import pfresp_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       pf_detect,
  input  wire logic [pfresp_pkg::CFG_W-1:0] cfg,
  input  wire logic                       nvm_runtime_write_permit,
  input  wire logic [pfresp_pkg::VOLT_W-1:0] pack_volt,
  input  wire logic [pfresp_pkg::VOLT_W-1:0] stack_volt,
  input  wire logic [pfresp_pkg::VOLT_W-1:0] min_blow_volt,
  input  wire logic                       nvm_ready,
  input  wire logic                       nvm_done,
  input  wire logic                       pf_status_in_ram,
  input  wire logic                       partial_reset,
  input  wire logic                       host_reg_on_cmd,
  output logic                            pf_latched,
  output logic                            switch_off,
  output logic                            fuse_drive,
  output logic                            regulator_off,
  output logic                            nvm_program,
  output logic                            ram_status_keep,
  output logic                            deepest_sleep_mode
);

  pfresp_state_t   state_q;
  pfresp_state_t   state_d;
  logic [CFG_W-1:0] cfg_q;
  logic            pf_q;
  logic            reg_off_q;
  logic            nvm_prog_q;
  logic            nvm_fin_q;
  logic            ram_keep_q;
  logic            blow_start_q;
  logic            blow_started_q;
  logic            sleep_q;
  logic            blow_drive;
  logic            blow_done;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  function automatic logic cfg_bit(input logic [CFG_W-1:0] c,
                                   input int unsigned pos);
    cfg_bit = c[pos];
  endfunction

  wire first_fail  = pf_detect && !pf_q;
  wire use_pack    = cfg_bit(cfg_q, BIT_SRC_SEL);
  wire blow_en     = cfg_bit(cfg_q, BIT_BLOW_EN);
  wire rec_en      = cfg_bit(cfg_q, BIT_RECORD_EN);
  wire sleep_en    = cfg_bit(cfg_q, BIT_SLEEP_EN);
  wire regoff_en   = cfg_bit(cfg_q, BIT_REG_OFF_EN);
  wire swoff_en    = cfg_bit(cfg_q, BIT_SWITCH_OFF);
  // selected voltage must exceed the threshold
  wire [VOLT_W-1:0] gate_volt = use_pack ? pack_volt
                                         : stack_volt;
  wire volt_ok     = gate_volt > min_blow_volt;
  wire want_nvm    = rec_en && nvm_runtime_write_permit;
  wire blow_fin    = !blow_en || blow_done;
  wire nvm_fin     = !want_nvm || nvm_fin_q;
  wire acts_done   = blow_fin && nvm_fin;
  wire blow_go     = state_q == PFR_ACT && blow_en && volt_ok
                     && !blow_started_q;

  // -------------------------------------------------------------------
  // state machine
  // -------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PFR_IDLE:       state_d = first_fail ? PFR_ACT : PFR_IDLE;
      PFR_ACT:        state_d = PFR_SLEEP_WAIT;
      PFR_SLEEP_WAIT:
        if (acts_done)
          state_d = sleep_en ? PFR_SLEEP : PFR_DONE;
      PFR_SLEEP:      state_d = PFR_SLEEP;
      PFR_DONE:       state_d = PFR_DONE;
      default:        state_d = PFR_IDLE;
    endcase
  end

  // blow stays armed while waiting so a later voltage rise still fires
  wire blow_arm = (state_q == PFR_ACT || state_q == PFR_SLEEP_WAIT)
                  && blow_en && volt_ok && !blow_started_q;

  // -------------------------------------------------------------------
  // failure latch and sampled configuration
  // -------------------------------------------------------------------
  // enables are frozen at the first failure; later edits do not count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= PFR_IDLE;
      cfg_q   <= CFG_RESET;
      pf_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // only the first failure of a run captures; a failure after a
      // partial reset must not reopen the enables
      if (first_fail && state_q == PFR_IDLE)
        cfg_q <= cfg;
      // partial reset keeps status only if ram keeping was armed or nvm programming finished
      if (partial_reset && !ram_keep_q && !nvm_fin_q)
        pf_q <= 1'b0;
      else if (pf_detect || pf_status_in_ram)
        pf_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // fuse blow
  // -------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      blow_start_q   <= 1'b0;
      blow_started_q <= 1'b0;
    end
    else
    begin
      blow_start_q   <= blow_arm;
      blow_started_q <= blow_started_q || blow_arm;
    end
  end

  pfresp_blow_timer u_blow
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (blow_start_q),
    .drive   (blow_drive),
    .done    (blow_done)
  );

  // -------------------------------------------------------------------
  // nvm record, ram keep, regulators, sleep
  // -------------------------------------------------------------------
  // programming waits for nvm_ready, which reflects supply and temp
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nvm_prog_q <= 1'b0;
      nvm_fin_q  <= 1'b0;
      ram_keep_q <= 1'b0;
      reg_off_q  <= 1'b0;
      sleep_q    <= 1'b0;
    end
    else
    begin
      nvm_prog_q <= state_q != PFR_IDLE && want_nvm && !nvm_fin_q
                    && nvm_ready && !nvm_done;
      nvm_fin_q  <= nvm_fin_q || (nvm_prog_q && nvm_done);
      ram_keep_q <= ram_keep_q
                    || (state_q == PFR_ACT && rec_en
                        && !nvm_runtime_write_permit);
      // host command wins so the regulators can always come back
      if (host_reg_on_cmd)
        reg_off_q <= 1'b0;
      else if (state_q == PFR_ACT && regoff_en)
        reg_off_q <= 1'b1;
      sleep_q    <= sleep_q || state_d == PFR_SLEEP;
    end
  end

  assign pf_latched         = pf_q;
  assign switch_off         = pf_q && (state_q == PFR_IDLE ? cfg[BIT_SWITCH_OFF]
                                                           : swoff_en);
  assign fuse_drive         = blow_drive;
  assign regulator_off      = reg_off_q;
  assign nvm_program        = nvm_prog_q;
  assign ram_status_keep    = ram_keep_q;
  assign deepest_sleep_mode = sleep_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_blow_needs_volt: assert property (
    blow_start_q |-> $past(volt_ok) && $past(blow_en))
    else $error("fuse blow started without enable or voltage");
  chk_stack_source: assert property (
    (blow_arm && !use_pack) |-> stack_volt > min_blow_volt)
    else $error("stack voltage not used for gating");
  chk_nvm_permit: assert property (
    nvm_prog_q |-> $past(want_nvm))
    else $error("nvm programmed without record enable and permit");
  chk_nvm_ready: assert property (
    nvm_prog_q |-> $past(nvm_ready))
    else $error("nvm programmed while not ready");
  chk_no_blow_dis: assert property (
    (state_q != PFR_IDLE && !blow_en) |-> !blow_arm)
    else $error("fuse armed while blow disabled");
  chk_sleep_waits: assert property (
    $rose(sleep_q) |-> $past(acts_done) && $past(sleep_en))
    else $error("sleep entered before actions done");
  chk_sleep_hold: assert property (
    sleep_q |=> sleep_q)
    else $error("deepest sleep left");
  chk_switch_hold: assert property (
    (state_q != PFR_IDLE && swoff_en && pf_q && !partial_reset)
      |=> switch_off)
    else $error("switches came back on after failure");
  chk_reg_off: assert property (
    (state_q == PFR_ACT && regoff_en && !host_reg_on_cmd) |=> reg_off_q)
    else $error("regulators not turned off");
  chk_reg_on_cmd: assert property (
    host_reg_on_cmd |=> !reg_off_q)
    else $error("host command did not restore regulators");
  chk_cfg_frozen: assert property (
    (state_q != PFR_IDLE) |=> $stable(cfg_q))
    else $error("config changed after failure");

  cov_blow:  cover property (blow_start_q ##[1:100] blow_done);
  cov_sleep: cover property ($rose(sleep_q));
  cov_nvm:   cover property (nvm_prog_q && nvm_done);
  cov_ram:   cover property ($rose(ram_keep_q));

endmodule

// ===== tb/pfresp_nvm_model.sv
// pfresp_nvm_model: the on-chip nvm programmer seen by the response block
// assumes nvm_program is a level request held until nvm_done rises
`timescale 1ns/1ps
module pfresp_nvm_model
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       nvm_program,
  input  wire logic       cond_ok,
  input  wire logic [6:0] delay,
  output logic            nvm_ready,
  output logic            nvm_done
);
  logic [6:0] cnt_q;
  // ready follows supply and temperature; low must hold programming off
  assign nvm_ready = cond_ok;
  // done rises delay+1 cycles into a request and stays up until reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q    <= 7'h00;
      nvm_done <= 1'b0;
    end
    else if (nvm_program && !nvm_done)
    begin
      cnt_q    <= cnt_q + 7'h01;
      nvm_done <= (cnt_q == delay);
    end
  end
endmodule

// ===== tb/test_permanent_fail_response.sv
// test_permanent_fail_response: random failure responses on pfresp_top
// assumes the nvm model answers programming requests
`timescale 1ns/1ps
module test_permanent_fail_response;
  import pfresp_pkg::*;
  logic        clk, sys_rst, pf_detect, pm, cond_ok, part_rst, host_cmd;
  logic [7:0]  cfg, c;
  logic [15:0] pack_v, stack_v, min_v, pv, sv, mv;
  logic [6:0]  dly;
  logic        nvm_ready, nvm_done, pf_latched, switch_off, fuse_drive;
  logic        regulator_off, nvm_program, ram_keep, sleep, prog_seen;
  int          failures, n_checks, cyc, fuse_n;

  // -------------------------------------------------------------------
  // clock, design, partner
  // -------------------------------------------------------------------
  always #12.5 clk = ~clk;
  pfresp_top dut_u (.clk(clk), .sys_rst(sys_rst), .pf_detect(pf_detect),
    .cfg(cfg), .nvm_runtime_write_permit(pm), .pack_volt(pack_v),
    .stack_volt(stack_v), .min_blow_volt(min_v), .nvm_ready(nvm_ready),
    .nvm_done(nvm_done), .pf_status_in_ram(1'b0),
    .partial_reset(part_rst), .host_reg_on_cmd(host_cmd),
    .pf_latched(pf_latched), .switch_off(switch_off),
    .fuse_drive(fuse_drive), .regulator_off(regulator_off),
    .nvm_program(nvm_program), .ram_status_keep(ram_keep),
    .deepest_sleep_mode(sleep));
  pfresp_nvm_model nvm_u (.clk(clk), .sys_rst(sys_rst),
    .nvm_program(nvm_program), .cond_ok(cond_ok), .delay(dly),
    .nvm_ready(nvm_ready), .nvm_done(nvm_done));

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // expected fuse pulse length; equal voltage is not enough
  function automatic logic [15:0] exp_fuse(input logic [7:0] k);
    if (k[4] && ((k[7] ? pv : sv) > mv))
      return 16'(BLOW_CYCLES);
    return 16'h0000;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a hang costs a mismatch; 24 runs of about 230 cycles fit well below
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      failures++;
      stop_test();
    end
  end

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial
  begin
    clk = 0; sys_rst = 1; pf_detect = 0; pm = 0; cond_ok = 0;
    part_rst = 0; host_cmd = 0; cfg = CFG_RESET; dly = 7'h00;
    pack_v = 16'h0000; stack_v = 16'h0000; min_v = 16'h0000;
    void'($urandom(81944));
    for (int i = 0; i < 24; i++)
    begin
      c = $urandom; pv = $urandom; sv = $urandom; mv = $urandom;
      if (i == 0) c = 8'hFF;
      if (i == 1) c = CFG_RESET;
      if (i == 2) mv = c[7] ? pv : sv;
      @(posedge clk);
      sys_rst <= 1'b1; cfg <= c; pm <= $urandom; dly <= $urandom;
      pack_v <= pv; stack_v <= sv; min_v <= mv; cond_ok <= 1'b0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      pf_detect <= 1'b1;
      @(posedge clk);
      pf_detect <= 1'b0;
      cfg <= ~c; // captured enables must not follow this
      fuse_n = 0;
      prog_seen = 0;
      for (int k = 0; k < 220; k++)
      begin
        @(posedge clk);
        pf_detect <= $urandom; // later detections must change nothing
        if (k == 20) cond_ok <= 1'b1;
        #1;
        fuse_n += int'(fuse_drive);
        prog_seen |= nvm_program;
        if (k < 20) chk(16'(nvm_program), 16'h0000);
        chk(16'(switch_off), 16'(c[1]));
        if (sleep && (fuse_drive || (c[5] && pm && !nvm_done)))
          chk(16'(sleep), 16'h0000);
      end
      chk(16'(fuse_n), exp_fuse(c));
      chk(16'(prog_seen), 16'(c[5] && pm));
      chk(16'(regulator_off), 16'(c[2]));
      chk(16'(sleep), 16'(c[3] && (!c[4] || exp_fuse(c) != 0)));
      chk(16'(ram_keep), 16'(c[5] && !pm));
      chk(16'(pf_latched), 16'h0001);
      @(posedge clk);
      pf_detect <= 1'b0; host_cmd <= 1'b1; part_rst <= 1'b1;
      @(posedge clk);
      host_cmd <= 1'b0; part_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(16'(regulator_off), 16'h0000);
      chk(16'(pf_latched), 16'(c[5]));
    end
    stop_test();
  end
endmodule
